//--- dv/sdc_ctrl_asserts.sv
// Port timing checker of the DRAM command controller, bound to its top.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defines.svh"
module sdc_ctrl_asserts
    import sdc_pkg::*;
#(
    parameter int TW = 8,
    parameter int PD_MAX_CYC = 50
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input wire sdc_req_s i_req,
    input wire logic o_req_ready,
    input wire logic o_req_reject,
    input wire sdc_pins_s o_pins,
    input wire sdc_dev_e o_dev_state,
    input wire logic o_pd_expired
);
    // Pin pattern, quiet bus, and taken or accepted request.
    wire logic [2:0] pat = {o_pins.ras_n, o_pins.cas_n, o_pins.we_n};
    wire logic quiet = o_pins.cs_n || (pat == `SDC_P_NOP);
    wire logic take = i_req_valid && o_req_ready;
    wire logic good = take && !o_req_reject;
    wire logic act_p = !o_pins.cs_n && (pat == `SDC_P_ACT);
    wire logic acc_p = !o_pins.cs_n && (pat == `SDC_P_RD || pat == `SDC_P_WR);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_busy_not_ready: assert property (o_dev_state == SDC_D_BUSY |-> !o_req_ready)
        else $error("ready high while busy");
    a_ref_holds_off: assert property (!o_pins.cs_n && o_pins.cke && pat == `SDC_P_REF
        |-> ##1 (!o_req_ready) [*5])
        else $error("request taken during refresh");
    a_pdn_entry: assert property (good && i_req.cmd == SDC_C_PDN |=>
        !o_pins.cke && quiet && o_dev_state == SDC_D_PDN)
        else $error("power-down entry wrong");
    a_sref_entry: assert property (good && i_req.cmd == SDC_C_SREF |=>
        !o_pins.cke && !o_pins.cs_n && pat == `SDC_P_REF)
        else $error("self refresh entry wrong");
    a_reject_silent: assert property (take && o_req_reject |=>
        quiet && $stable(o_pins.cke))
        else $error("refused request reached the pins");
    a_cke_low_held: assert property (!o_pins.cke && !(take && i_req.cmd == SDC_C_WAKE) |=>
        !o_pins.cke)
        else $error("clock enable rose without wake");
    a_pdn_exit: assert property ($rose(o_pins.cke) && $past(o_dev_state) == SDC_D_PDN |->
        quiet && o_dev_state == SDC_D_RUN)
        else $error("power-down exit wrong");
    a_xsr_nops: assert property ($rose(o_pins.cke) && $past(o_dev_state) == SDC_D_SREF |->
        (quiet && !o_req_ready) [*3])
        else $error("self refresh exit not quiet");
    a_susp_exit: assert property ($rose(o_pins.cke) && $past(o_dev_state) == SDC_D_SUSP
        |-> o_dev_state == SDC_D_RUN && o_req_ready)
        else $error("suspend exit not resumed");
    a_act_to_acc: assert property (act_p |=> !(acc_p && o_pins.ba == $past(o_pins.ba)))
        else $error("access during row activation");
endmodule : sdc_ctrl_asserts
bind sdc_ctrl sdc_ctrl_asserts #(.TW(TW), .PD_MAX_CYC(PD_MAX_CYC)) u_chk (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_req_reject(o_req_reject), .o_pins(o_pins), .o_dev_state(o_dev_state),
    .o_pd_expired(o_pd_expired));
`default_nettype wire

//--- dv/sdc_dev_model.sv
// Behavioural DRAM device that counts illegal command sequences on its pins.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defines.svh"
module sdc_dev_model
    import sdc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire sdc_pins_s i_pins,
    output var logic [15:0] o_errs
);
    logic cke_q; // Clock enable seen at the previous edge.
    logic sref_q; // Self refresh is held.
    logic [3:0] open_q; // Banks with an open row.
    int busy; // Device-wide quiet time left.
    int trcd [4]; // Row activation time left per bank.
    wire logic [2:0] p = {i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
    wire logic quiet = i_pins.cs_n || (p == `SDC_P_NOP);
    // Commands count only with both enable samples high; suspend ignores them.
    wire logic live = !quiet && i_pins.cke && cke_q;
    // One process keeps the whole device, so errors count in one place, at most one per edge.
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            cke_q <= 1'b1;
            sref_q <= 1'b0;
            open_q <= 4'h0;
            busy <= 0;
            o_errs <= 16'h0;
            trcd <= '{0, 0, 0, 0};
        end else begin
            cke_q <= i_pins.cke;
            if (busy > 0) busy <= busy - 1;
            for (int b = 0; b < 4; b++) if (trcd[b] > 0) trcd[b] <= trcd[b] - 1;
            if (cke_q && !i_pins.cke && !quiet && p == `SDC_P_REF) sref_q <= 1'b1;
            if (!cke_q && i_pins.cke && sref_q) begin
                sref_q <= 1'b0;
                busy <= `SDC_TXSR_CYC;
                if (!quiet) o_errs <= o_errs + 16'h1;
            end
            if (live) begin
                if (busy > 1) o_errs <= o_errs + 16'h1;
                case (p)
                    `SDC_P_ACT: begin
                        if (open_q[i_pins.ba]) o_errs <= o_errs + 16'h1;
                        open_q[i_pins.ba] <= 1'b1;
                        trcd[i_pins.ba] <= `SDC_TRCD_CYC;
                    end
                    `SDC_P_RD, `SDC_P_WR: begin
                        // Either precharge variant is taken; a row must be open.
                        if (!open_q[i_pins.ba] || trcd[i_pins.ba] > 1) begin
                            o_errs <= o_errs + 16'h1;
                        end
                        if (i_pins.a[10]) open_q[i_pins.ba] <= 1'b0;
                    end
                    `SDC_P_PRE: begin
                        // An idle bank simply stays idle.
                        if (i_pins.a[10]) open_q <= 4'h0;
                        else open_q[i_pins.ba] <= 1'b0;
                        if (i_pins.a[10]) busy <= `SDC_TRP_CYC;
                    end
                    `SDC_P_REF, `SDC_P_MRS: begin
                        if (open_q != 4'h0) o_errs <= o_errs + 16'h1;
                        busy <= (p == `SDC_P_REF) ? `SDC_TRC_CYC : `SDC_TMRD_CYC;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule : sdc_dev_model
`default_nettype wire

//--- dv/test_sdc_ctrl.sv
// Self-checking bench of the DRAM command controller.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defines.svh"
module test_sdc_ctrl
    import sdc_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic vld = 1'b0;
    sdc_req_s rq = '0;
    sdc_pins_s pv; // Pins seen after a request was taken.
    wire logic rdy, rej, pdx;
    wire sdc_pins_s pins;
    wire sdc_dev_e dev;
    wire logic [15:0] merr;
    int fails = 0;
    int comparisons = 0;
    int seed = 32'hd84196c9;
    int r;
    logic ap;
    always #5 i_mclk = ~i_mclk;
    // Short power-down limit keeps the run brief.
    sdc_ctrl #(.PD_MAX_CYC(50)) uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req_valid(vld),
        .i_req(rq), .o_req_ready(rdy), .o_req_reject(rej), .o_pins(pins), .o_dev_state(dev),
        .o_pd_expired(pdx));
    sdc_dev_model u_dev (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_pins(pins), .o_errs(merr));
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    // Expected pin pattern of each command.
    function automatic logic [2:0] pat_of(input sdc_cmd_e c);
        case (c)
            SDC_C_ACT: return `SDC_P_ACT;
            SDC_C_RD: return `SDC_P_RD;
            SDC_C_WR: return `SDC_P_WR;
            SDC_C_BST: return `SDC_P_BST;
            SDC_C_PRE, SDC_C_PREA: return `SDC_P_PRE;
            SDC_C_REF, SDC_C_SREF: return `SDC_P_REF;
            SDC_C_MRS: return `SDC_P_MRS;
            default: return `SDC_P_NOP;
        endcase
    endfunction : pat_of
    // Valid is held up after the take, so back-to-back calls never toggle it.
    task automatic req(input sdc_cmd_e c, input logic [1:0] b, input logic a, input logic rj);
        vld = 1'b1;
        rq = '{cmd: c, bank: b, auto_pre: a, addr: 11'($random(seed))};
        while (rdy !== 1'b1) begin
            @(negedge i_mclk);
        end
        #1 chk("reject", rj, rej);
        @(negedge i_mclk);
        pv = pins;
    endtask : req
    // Accepted request: pattern, bank and address bit ten are checked.
    task automatic ok(input sdc_cmd_e c, input logic [1:0] b, input logic a);
        req(c, b, a, 1'b0);
        chk("pattern", pat_of(c), {pv.ras_n, pv.cas_n, pv.we_n});
        if (c inside {SDC_C_ACT, SDC_C_RD, SDC_C_WR, SDC_C_PRE}) chk("bank", b, pv.ba);
        if (c inside {SDC_C_RD, SDC_C_WR}) chk("a10", a, pv.a[10]);
        if (c == SDC_C_PREA) chk("a10", 1'b1, pv.a[10]);
    endtask : ok
    task automatic idle(input int n);
        vld = 1'b0;
        repeat (n) @(negedge i_mclk);
    endtask : idle
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done
    // Main sequence: directed corners first, then random traffic.
    initial begin
        repeat (2) @(negedge i_mclk);
        i_rstn = 1'b1;
        chk("cke", 1'b1, pins.cke);
        chk("cs_n", 1'b1, pins.cs_n);
        chk("state", SDC_D_RUN, dev);
        done("reset");
        for (int b = 0; b < 4; b++) begin
            ok(SDC_C_ACT, b[1:0], 1'b0);
        end
        req(SDC_C_RD, 2'h3, 1'b0, 1'b1);
        idle(2);
        ap = 1'($random(seed));
        ok(SDC_C_RD, 2'h0, 1'b0);
        ok(SDC_C_WR, 2'h0, 1'b0);
        ok(SDC_C_RD, 2'h0, 1'b0);
        req(SDC_C_BST, 2'h1, 1'b0, 1'b1);
        ok(SDC_C_BST, 2'h0, 1'b0);
        ok(SDC_C_WR, 2'h1, ap);
        ok(SDC_C_PRE, 2'h0, 1'b0);
        req(SDC_C_ACT, 2'h0, 1'b0, 1'b1);
        idle(3);
        ok(SDC_C_PRE, 2'h0, 1'b0);
        req(SDC_C_REF, 2'h0, 1'b0, 1'b1);
        idle(6);
        ok(SDC_C_PREA, 2'h0, 1'b0);
        idle(3);
        ok(SDC_C_REF, 2'h0, 1'b0);
        chk("ready", 1'b0, rdy);
        idle(8);
        ok(SDC_C_MRS, 2'h0, 1'b0);
        idle(3);
        done("banks");
        req(SDC_C_SUSP, 2'h0, 1'b0, 1'b1);
        ok(SDC_C_ACT, 2'h2, 1'b0);
        idle(3);
        ok(SDC_C_RD, 2'h2, 1'b0);
        ok(SDC_C_SUSP, 2'h2, 1'b0);
        chk("cke", 1'b0, pv.cke);
        chk("state", SDC_D_SUSP, dev);
        req(SDC_C_ACT, 2'h0, 1'b0, 1'b1);
        ok(SDC_C_WAKE, 2'h0, 1'b0);
        chk("cke", 1'b1, pv.cke);
        ok(SDC_C_BST, 2'h2, 1'b0);
        ok(SDC_C_PREA, 2'h0, 1'b0);
        idle(3);
        done("suspend");
        ok(SDC_C_PDN, 2'h0, 1'b0);
        chk("cke", 1'b0, pv.cke);
        chk("state", SDC_D_PDN, dev);
        idle(55);
        chk("expired", 1'b1, pdx);
        ok(SDC_C_WAKE, 2'h0, 1'b0);
        chk("cke", 1'b1, pv.cke);
        chk("state", SDC_D_RUN, dev);
        ok(SDC_C_SREF, 2'h0, 1'b0);
        chk("cke", 1'b0, pv.cke);
        idle(3);
        ok(SDC_C_WAKE, 2'h0, 1'b0);
        chk("ready", 1'b0, rdy);
        idle(10);
        chk("ready", 1'b1, rdy);
        done("power");
        // A new request is drawn only while ready is high, so each drawn one is taken at the next edge.
        repeat (300) begin
            @(negedge i_mclk);
            vld = 1'b1;
            r = $random(seed);
            if (rdy === 1'b1) rq = '{cmd: sdc_cmd_e'(4'(r[3:0] % 4'h9)), bank: r[5:4],
                auto_pre: r[6], addr: r[17:7]};
        end
        idle(10);
        chk("model", 16'h0, merr);
        done("random");
        final_report;
    end
    // Watchdog cuts a hang short.
    initial begin
        #50000;
        fails++;
        final_report;
    end
endmodule : test_sdc_ctrl
`default_nettype wire

//--- hdl/sdc_bank.sv
// One bank tracker: state and countdown timer for a single bank.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defines.svh"
module sdc_bank
    import sdc_pkg::*;
#(
    parameter int TW = `SDC_TMR_W
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_adv,
    input wire logic i_act,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic i_ap,
    input wire logic i_pre,
    input wire logic i_stop,
    input wire logic [TW-1:0] i_trp,
    input wire logic [TW-1:0] i_trcd,
    output sdc_bank_e o_state,
    output logic o_tdone
);
    sdc_bank_e state_r;
    sdc_bank_e state_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic tmr_zero;

    assign tmr_zero = (tmr_r == '0);
    assign o_state = state_r;
    assign o_tdone = tmr_zero;

    // Next state; the bank only moves on enabled (not suspended, powered down or in self refresh) edges.
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        if (i_adv) begin
            if (!tmr_zero) begin
                tmr_nxt = tmr_r - 1'b1;
            end
            unique case (state_r)
                SDC_B_IDLE: begin
                    if (i_act) begin // (RULE8)
                        state_nxt = SDC_B_ACTV;
                        tmr_nxt = i_trcd;
                    end
                    // A precharge here leaves the bank idle. (RULE10)
                end
                SDC_B_ACTV: begin
                    if (tmr_zero) begin // (RULE19)
                        state_nxt = SDC_B_OPEN;
                    end
                end
                SDC_B_OPEN, SDC_B_READ, SDC_B_WRITE: begin
                    if (i_pre) begin // (RULE11)
                        state_nxt = SDC_B_PRE;
                        tmr_nxt = i_trp;
                    end else if ((i_rd || i_wr) && i_ap) begin // (RULE15)
                        state_nxt = SDC_B_AP;
                        tmr_nxt = i_trp;
                    end else if (i_rd) begin // (RULE12)
                        state_nxt = SDC_B_READ;
                    end else if (i_wr) begin // (RULE13)
                        state_nxt = SDC_B_WRITE;
                    end else if (i_stop) begin // (RULE14)
                        state_nxt = SDC_B_OPEN;
                    end
                end
                SDC_B_AP, SDC_B_PRE: begin
                    if (tmr_zero) begin // (RULE17)
                        state_nxt = SDC_B_IDLE;
                    end
                end
                default: begin
                    state_nxt = SDC_B_IDLE;
                end
            endcase
        end
    end

    // State and timer flops.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_r <= SDC_B_IDLE;
            tmr_r <= '0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
        end
    end
endmodule : sdc_bank
`default_nettype wire

//--- hdl/sdc_ctrl.sv
// Controller that drives the DRAM command and clock-enable pins legally.
// How it works
// (RULE1) Clock enable history chooses each edge's action.
// (RULE2) Falling enable enters power-down, self refresh, suspend.
// (RULE3) Power-down exit: enable high with no-op.
// (RULE4) Self refresh exit: no-ops until exit time.
// (RULE5) Suspend exit resumes commands next edge.
// (RULE6) Only listed combinations are ever issued.
// (RULE7) Inhibit and no-op keep operations running.
// (RULE8) Idle bank: activate, refresh, mode load patterns.
// (RULE9) Refresh and mode load need all banks idle.
// (RULE10) Precharge of idle bank is no-op.
// (RULE11) Open row: read, write, precharge patterns.
// (RULE12) Reading bank accepts read, write, precharge, stop.
// (RULE13) Writing bank accepts read, write, precharge, stop.
// (RULE14) Burst stop hits the latest burst.
// (RULE15) Auto-precharge variants allowed wherever access allowed.
// (RULE16) Precharge all needs every bank ready.
// (RULE17) No command to precharging or activating bank.
// (RULE18) Refresh, mode load, precharge all: no-ops only.
// (RULE19) Idle after tRP, active after tRCD.
// (RULE20) Power-down limited to the refresh interval; the code only raises o_pd_expired and stays powered down.
// (RULE21) Suspend freezes bursts and holds inputs.
// (RULE22) Per-bank timers plus device timers decide legality.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defines.svh"
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int TW = `SDC_TMR_W,
    parameter int PD_MAX_CYC = `SDC_PD_MAX_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input wire sdc_req_s i_req,
    output logic o_req_ready,
    output logic o_req_reject,
    output sdc_pins_s o_pins,
    output sdc_dev_e o_dev_state,
    output logic o_pd_expired
);
    localparam logic [TW-1:0] TRP = TW'(`SDC_TRP_CYC);
    localparam logic [TW-1:0] TRCD = TW'(`SDC_TRCD_CYC);
    localparam logic [TW-1:0] TRC = TW'(`SDC_TRC_CYC);
    localparam logic [TW-1:0] TMRD = TW'(`SDC_TMRD_CYC);
    localparam logic [TW-1:0] TXSR = TW'(`SDC_TXSR_CYC);
    localparam logic [1:0] XNOPS = 2'(`SDC_XSR_NOPS);

    sdc_dev_e dev_r; // Device-wide mode.
    sdc_dev_e dev_nxt;
    logic [TW-1:0] dtmr_r; // Device timer for tRC, tMRD, tRP-all and tXSR.
    logic [TW-1:0] dtmr_nxt;
    logic [1:0] nop_cnt_r; // No-ops issued during the self refresh exit.
    logic [31:0] pd_cnt_r; // Cycles spent in power-down.
    logic cke_r; // Clock enable level driven on the current edge.
    logic cke_nxt;
    sdc_pins_s pins_r;
    sdc_pins_s pins_nxt;
    logic [`SDC_NBANK-1:0] last_burst_r; // One-hot bank of the latest burst.
    sdc_bank_e bst [`SDC_NBANK];
    logic [`SDC_NBANK-1:0] b_act, b_rd, b_wr, b_pre, b_stop;
    logic [`SDC_NBANK-1:0] b_idle, b_open, b_burst, b_prechg_ok;

    // Request decode.
    wire logic take = i_req_valid && o_req_ready;
    wire sdc_bank_e tgt = bst[i_req.bank];
    wire logic all_idle = &b_idle;
    wire logic any_burst = |b_burst;
    wire logic dtmr_zero = (dtmr_r == '0);
    wire logic tgt_acc = (tgt == SDC_B_OPEN) || (tgt == SDC_B_READ) || (tgt == SDC_B_WRITE);
    wire logic tgt_burst = (tgt == SDC_B_READ) || (tgt == SDC_B_WRITE);

    // Legality of the request against the tracked state.
    logic legal;
    always_comb begin
        legal = 1'b0;
        unique case (i_req.cmd)
            SDC_C_NOP: legal = 1'b1; // (RULE7)
            SDC_C_ACT: legal = (tgt == SDC_B_IDLE); // (RULE8)
            SDC_C_RD, SDC_C_WR: legal = tgt_acc; // (RULE11) (RULE15)
            SDC_C_BST: legal = tgt_burst && last_burst_r[i_req.bank]; // (RULE14)
            SDC_C_PRE: legal = tgt_acc || (tgt == SDC_B_IDLE); // (RULE10) (RULE17)
            SDC_C_PREA: legal = &b_prechg_ok; // (RULE16)
            SDC_C_REF, SDC_C_MRS: legal = all_idle; // (RULE9)
            SDC_C_PDN: legal = all_idle; // (RULE2)
            SDC_C_SREF: legal = all_idle; // (RULE2)
            SDC_C_SUSP: legal = any_burst; // (RULE2)
            SDC_C_WAKE: legal = 1'b0;
            default: legal = 1'b0;
        endcase
    end

    // Power-down, self refresh and suspend only leave on a wake request.
    wire logic in_low = (dev_r == SDC_D_PDN) || (dev_r == SDC_D_SREF) || (dev_r == SDC_D_SUSP);
    // Ready only while the device can take a new command this edge. (RULE6) (RULE18)
    assign o_req_ready = (dev_r == SDC_D_RUN) || in_low;
    wire logic wake = take && in_low && (i_req.cmd == SDC_C_WAKE);
    wire logic issue = take && (dev_r == SDC_D_RUN) && legal;
    assign o_req_reject = take && !wake && !issue;

    // Per-bank strobes; only issued commands reach the trackers.
    genvar g;
    generate
        for (g = 0; g < `SDC_NBANK; g++) begin : g_bank
            wire logic hit = (i_req.bank == 2'(g));
            assign b_act[g] = issue && hit && (i_req.cmd == SDC_C_ACT);
            assign b_rd[g] = issue && hit && (i_req.cmd == SDC_C_RD);
            assign b_wr[g] = issue && hit && (i_req.cmd == SDC_C_WR);
            // Precharge of the addressed bank, open or idle, or precharge all of every bank.
            assign b_pre[g] = issue && ((hit && (i_req.cmd == SDC_C_PRE))
                              || (i_req.cmd == SDC_C_PREA));
            assign b_stop[g] = issue && hit && (i_req.cmd == SDC_C_BST);
            assign b_idle[g] = (bst[g] == SDC_B_IDLE);
            assign b_open[g] = (bst[g] == SDC_B_OPEN);
            assign b_burst[g] = (bst[g] == SDC_B_READ) || (bst[g] == SDC_B_WRITE);
            assign b_prechg_ok[g] = b_idle[g] || b_open[g] || b_burst[g];
            // Trackers freeze while suspended or powered down. (RULE21) (RULE22)
            sdc_bank #(
                .TW(TW)
            ) u_bank (
                .i_mclk(i_mclk),
                .i_rstn(i_rstn),
                .i_adv(!in_low),
                .i_act(b_act[g]),
                .i_rd(b_rd[g]),
                .i_wr(b_wr[g]),
                .i_ap(i_req.auto_pre),
                .i_pre(b_pre[g]),
                .i_stop(b_stop[g]),
                .i_trp(TRP),
                .i_trcd(TRCD),
                .o_state(bst[g]),
                .o_tdone()
            );
        end
    endgenerate

    // Device mode, clock enable and pin pattern for the coming edge.
    always_comb begin
        dev_nxt = dev_r;
        dtmr_nxt = dtmr_zero ? dtmr_r : dtmr_r - 1'b1;
        cke_nxt = cke_r;
        pins_nxt = '{cke: cke_r, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                     ba: 2'h0, a: 11'h000};
        unique case (dev_r)
            SDC_D_RUN: begin
                if (issue) begin
                    pins_nxt.ba = i_req.bank;
                    pins_nxt.a = i_req.addr;
                    unique case (i_req.cmd)
                        SDC_C_ACT: {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} = `SDC_P_ACT;
                        SDC_C_RD, SDC_C_WR: begin
                            {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} =
                                (i_req.cmd == SDC_C_RD) ? `SDC_P_RD : `SDC_P_WR;
                            pins_nxt.a[10] = i_req.auto_pre; // (RULE15)
                        end
                        SDC_C_BST: {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} = `SDC_P_BST;
                        SDC_C_PRE, SDC_C_PREA: begin
                            {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} = `SDC_P_PRE;
                            pins_nxt.a[10] = (i_req.cmd == SDC_C_PREA); // (RULE11)
                            if (i_req.cmd == SDC_C_PREA) begin // (RULE18)
                                dev_nxt = SDC_D_BUSY;
                                dtmr_nxt = TRP;
                            end
                        end
                        SDC_C_REF, SDC_C_MRS: begin
                            {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} =
                                (i_req.cmd == SDC_C_REF) ? `SDC_P_REF : `SDC_P_MRS;
                            dev_nxt = SDC_D_BUSY; // (RULE18)
                            dtmr_nxt = (i_req.cmd == SDC_C_REF) ? TRC : TMRD;
                        end
                        SDC_C_PDN: begin // (RULE2)
                            cke_nxt = 1'b0;
                            dev_nxt = SDC_D_PDN;
                        end
                        SDC_C_SREF: begin // (RULE2)
                            {pins_nxt.ras_n, pins_nxt.cas_n, pins_nxt.we_n} = `SDC_P_REF;
                            cke_nxt = 1'b0;
                            dev_nxt = SDC_D_SREF;
                        end
                        SDC_C_SUSP: begin // (RULE2)
                            cke_nxt = 1'b0;
                            dev_nxt = SDC_D_SUSP;
                        end
                        default: begin
                        end
                    endcase
                    pins_nxt.cke = cke_nxt;
                end
            end
            SDC_D_PDN, SDC_D_SREF, SDC_D_SUSP: begin
                // Both samples low: hold the mode. (RULE1) (RULE21)
                if (wake) begin
                    cke_nxt = 1'b1;
                    pins_nxt.cke = 1'b1;
                    // Exit with a no-op; suspend and power-down resume next edge. (RULE3) (RULE5)
                    if (dev_r == SDC_D_SREF) begin // (RULE4)
                        dev_nxt = SDC_D_XSR;
                        dtmr_nxt = TXSR;
                    end else begin
                        dev_nxt = SDC_D_RUN;
                    end
                end
            end
            SDC_D_XSR: begin
                // Only no-ops, at least two, until the exit time. (RULE4)
                if (dtmr_zero && (nop_cnt_r >= XNOPS)) begin
                    dev_nxt = SDC_D_RUN;
                end
            end
            SDC_D_BUSY: begin
                if (dtmr_zero) begin // (RULE18)
                    dev_nxt = SDC_D_RUN;
                end
            end
            default: dev_nxt = SDC_D_RUN;
        endcase
    end

    // Device flops.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            dev_r <= SDC_D_RUN;
            dtmr_r <= '0;
            cke_r <= 1'b1;
            pins_r <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        ba: 2'h0, a: 11'h000};
        end else begin
            dev_r <= dev_nxt;
            dtmr_r <= dtmr_nxt;
            cke_r <= cke_nxt;
            pins_r <= pins_nxt;
        end
    end

    // Counts no-ops during the self refresh exit; saturates at the minimum.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || (dev_r != SDC_D_XSR)) begin
            nop_cnt_r <= 2'h0;
        end else if (nop_cnt_r < XNOPS) begin
            nop_cnt_r <= nop_cnt_r + 2'h1;
        end
    end

    // Tracks the bank of the newest burst so a stop lands on it. (RULE14)
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            last_burst_r <= '0;
        end else if (|(b_rd | b_wr)) begin
            last_burst_r <= b_rd | b_wr;
        end
    end

    // Power-down watchdog: flags when the refresh interval is used up. (RULE20)
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || (dev_r != SDC_D_PDN)) begin
            pd_cnt_r <= '0;
            o_pd_expired <= 1'b0;
        end else begin
            pd_cnt_r <= pd_cnt_r + 32'h1;
            o_pd_expired <= (pd_cnt_r >= 32'(PD_MAX_CYC - 1));
        end
    end

    assign o_pins = pins_r;
    assign o_dev_state = dev_r;
endmodule : sdc_ctrl
`default_nettype wire

//--- hdl/sdc_defines.svh
// Timing counts and command encodings for the DRAM command controller.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_CLK_MHZ 100
`define SDC_TRP_NS 20
`define SDC_TRCD_NS 20
`define SDC_TRC_NS 70
`define SDC_TMRD_NS 20
`define SDC_TXSR_NS 80
`define SDC_TWR_NS 20
`define SDC_CYC(ns) (((ns) * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TRP_CYC `SDC_CYC(`SDC_TRP_NS)
`define SDC_TRCD_CYC `SDC_CYC(`SDC_TRCD_NS)
`define SDC_TRC_CYC `SDC_CYC(`SDC_TRC_NS)
`define SDC_TMRD_CYC `SDC_CYC(`SDC_TMRD_NS)
`define SDC_TXSR_CYC `SDC_CYC(`SDC_TXSR_NS)
`define SDC_TWR_CYC `SDC_CYC(`SDC_TWR_NS)
`define SDC_XSR_NOPS 2
`define SDC_PD_MAX_MS 64
`define SDC_PD_MAX_CYC (`SDC_PD_MAX_MS * `SDC_CLK_MHZ * 1000)
`define SDC_NBANK 4
`define SDC_TMR_W 8
// Pin pattern RAS# CAS# WE# with chip select low.
`define SDC_P_NOP 3'h7
`define SDC_P_ACT 3'h3
`define SDC_P_RD 3'h5
`define SDC_P_WR 3'h4
`define SDC_P_BST 3'h6
`define SDC_P_PRE 3'h2
`define SDC_P_REF 3'h1
`define SDC_P_MRS 3'h0
`endif

//--- hdl/sdc_pkg.sv
// Types shared by the DRAM command controller files.
package sdc_pkg;
    // Command that the user asks the controller to issue.
    typedef enum logic [3:0] {
        SDC_C_NOP, SDC_C_ACT, SDC_C_RD, SDC_C_WR, SDC_C_BST, SDC_C_PRE,
        SDC_C_PREA, SDC_C_REF, SDC_C_MRS, SDC_C_PDN, SDC_C_SREF, SDC_C_SUSP, SDC_C_WAKE
    } sdc_cmd_e;
    // Per-bank view kept by the controller.
    typedef enum logic [2:0] {
        SDC_B_IDLE, SDC_B_ACTV, SDC_B_OPEN, SDC_B_READ, SDC_B_WRITE, SDC_B_AP, SDC_B_PRE
    } sdc_bank_e;
    // Device-wide mode as seen through clock enable history.
    typedef enum logic [2:0] {
        SDC_D_RUN, SDC_D_PDN, SDC_D_SREF, SDC_D_SUSP, SDC_D_XSR, SDC_D_BUSY
    } sdc_dev_e;
    // User request carrier.
    typedef struct packed {
        sdc_cmd_e cmd;
        logic [1:0] bank;
        logic auto_pre;
        logic [10:0] addr;
    } sdc_req_s;
    // Command pins toward the device.
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [10:0] a;
    } sdc_pins_s;
endpackage : sdc_pkg
